//--- qdrcd_pkg.sv
package qdrcd_pkg;
  // Memory clock cycle is four system clock cycles, one per quarter phase
  localparam logic [1:0] PH_LAUNCH  = 2'h0;
  localparam logic [1:0] PH_KRISE   = 2'h1;
  localparam logic [1:0] PH_LAUNCH2 = 2'h2;
  localparam logic [1:0] PH_LAST    = 2'h3;
  // Default widths and the echo delay, in system clock cycles
  localparam int unsigned DATA_W_DEF   = 18;
  localparam int unsigned ADDR_W_DEF   = 19;
  localparam int unsigned ECHO_DLY_DEF = 1;
  localparam int unsigned ECHO_HALF    = 2;
  localparam int unsigned DDR_WORDS    = 2;
  // Resynchronisation latency search range
  localparam int unsigned LAT_W   = 5;
  localparam int unsigned MAX_LAT = 31;
  localparam logic [4:0]  LAT_MAX = 5'h1f;
  localparam logic [4:0]  LAT_RST = 5'h00;
  // Training pattern, one word per half cycle
  localparam logic [17:0] CAL_RISE = 18'h2_a5a5;
  localparam logic [17:0] CAL_FALL = 18'h1_5a5a;
  // Read slots that the output buffer can absorb
  localparam logic [1:0]  CREDITS_RST = 2'h2;
  // Calibration states, one-hot
  typedef enum logic [4:0] {
    CAL_IDLE  = 5'h01,
    CAL_WRITE = 5'h02,
    CAL_READ  = 5'h04,
    CAL_WAIT  = 5'h08,
    CAL_DONE  = 5'h10
  } qdrcd_cal_state_t;
endpackage

//--- qdrcd_pair_buf.sv
`timescale 1ns/10ps
`default_nettype none
module qdrcd_pair_buf #(
  parameter int unsigned W = 36
) (
  // Clock and reset
  input  wire logic         mclk_i,
  input  wire logic         resetn_i,
  // Fill side
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  // Drain side
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  initial begin
    if (W < 1) $error("Buffer width must be at least one bit");
  end

  logic [W-1:0] mem_q [2];
  logic         wptr_q;
  logic         rptr_q;
  logic [1:0]   count_q;
  logic         push;
  logic         pop;

  // Full and empty come straight from the count
  assign in_ready_o  = (count_q != 2'h2);
  assign out_valid_o = (count_q != 2'h0);
  assign out_data_o  = mem_q[rptr_q];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // Storage is written only, no reset needed on data
  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem_q[wptr_q] <= in_data_i;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wptr_q  <= 1'b0;
      rptr_q  <= 1'b0;
      count_q <= 2'h0;
    end else begin
      if (push) wptr_q <= ~wptr_q;
      if (pop) rptr_q <= ~rptr_q;
      count_q <= count_q + {1'b0, push} - {1'b0, pop};
    end
  end

  a_buf_no_overflow: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    count_q == 2'h2 && !pop |=> count_q == 2'h2)
    else $error("Buffer lost an entry while full");
endmodule
`default_nettype wire

//--- qdrcd_datapath.sv
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Launch and memory-clock source share frequency; memory clock lags 90 degrees.
// - Address, command and write data leave on the launch phase.
// - Memory clock pair comes from the lagging phase, centred in each word.
// - All memory outputs, clock pair included, leave from one matched output bank.
// - A shifted copy of the positive echo clock samples read data.
// - Captured read data moves into the system domain before use.
// - Negative echo clock is unused in clock-generator capture mode.
// - Echo clock is delayed so sampling sits mid data window.
// - Delay-line mode: shifted echo clocks drive strobe and inverted strobe.
// - At start-up a dummy write then read sets the resync latency.
// - Read data is double rate: one word per echo half cycle.
// - Delay-line mode recaptures on the same delayed positive echo edge.
module qdrcd_datapath #(
  parameter int unsigned DATA_W         = qdrcd_pkg::DATA_W_DEF,
  parameter int unsigned ADDR_W         = qdrcd_pkg::ADDR_W_DEF,
  parameter int unsigned ECHO_DLY       = qdrcd_pkg::ECHO_DLY_DEF,
  parameter bit          USE_DELAY_LINE = 1'b0
) (
  // Clock and reset
  input  wire logic              mclk_i,
  input  wire logic              resetn_i,
  // User command port
  output logic                   cmd_ready_o,
  input  wire logic              wr_req_i,
  input  wire logic              rd_req_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_rise_i,
  input  wire logic [DATA_W-1:0] wdata_fall_i,
  // User read data
  output logic                   rdata_valid_o,
  input  wire logic              rdata_ready_i,
  output logic [DATA_W-1:0]      rdata_rise_o,
  output logic [DATA_W-1:0]      rdata_fall_o,
  // Calibration status
  output logic                   cal_done_o,
  output logic [4:0]             cal_latency_o,
  // Memory outputs
  output logic                   mem_k_o,
  output logic                   mem_k_n_o,
  output logic [ADDR_W-1:0]      mem_addr_o,
  output logic                   mem_wr_n_o,
  output logic                   mem_rd_n_o,
  output logic [DATA_W-1:0]      mem_d_o,
  // Memory inputs
  input  wire logic              echo_clock_p_i,
  input  wire logic              echo_clock_n_i,
  input  wire logic [DATA_W-1:0] mem_q_i
);
  initial begin
    if (DATA_W < 1 || DATA_W > 18) $error("DATA_W must be 1 to 18");
    if (ADDR_W < 1) $error("ADDR_W must be at least 1");
    if (ECHO_DLY < 1 || ECHO_DLY >= qdrcd_pkg::ECHO_HALF) $error("ECHO_DLY out of range");
  end

  localparam logic [DATA_W-1:0] PAT_RISE = qdrcd_pkg::CAL_RISE[DATA_W-1:0];
  localparam logic [DATA_W-1:0] PAT_FALL = qdrcd_pkg::CAL_FALL[DATA_W-1:0];

  qdrcd_pkg::qdrcd_cal_state_t cal_q;
  logic [1:0]                  phase_q;
  logic                        k_q;
  logic [DATA_W-1:0]           fall_hold_q;
  logic                        launch_fire;
  logic                        launch_wr;
  logic                        launch_rd;
  logic [ADDR_W-1:0]           launch_addr;
  logic [DATA_W-1:0]           launch_rise;
  logic [DATA_W-1:0]           launch_fall;
  logic                        cmd_accept;
  logic [1:0]                  credits_q;
  logic [ECHO_DLY-1:0]         p_sh_q;
  logic                        strobe;
  logic                        strobe_prev_q;
  logic                        strobe_rise;
  logic                        strobe_inv_rise;
  logic [DATA_W-1:0]           rise_cap_q;
  logic [DATA_W-1:0]           fall_cap_q;
  logic                        fall_seen_q;
  logic [DATA_W-1:0]           pair_rise_q;
  logic [DATA_W-1:0]           pair_fall_q;
  logic                        pair_vld_q;
  logic                        pair_match;
  logic [4:0]                  cal_cnt_q;
  logic [4:0]                  lat_q;
  logic [qdrcd_pkg::MAX_LAT-1:0] pipe_q;
  logic                        deliver;
  logic                        buf_in_ready;
  logic                        pop;

  // Quarter-phase generator: launch on phase 0, memory clock a quarter later
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      phase_q <= qdrcd_pkg::PH_LAUNCH;
      k_q     <= 1'b0;
    end else begin
      phase_q <= phase_q + 2'h1;
      if (phase_q == qdrcd_pkg::PH_LAUNCH) k_q <= 1'b1;
      else if (phase_q == qdrcd_pkg::PH_LAUNCH2) k_q <= 1'b0;
    end
  end

  // Commands are taken only once trained and while a read has a buffer slot
  assign cmd_ready_o = (cal_q == qdrcd_pkg::CAL_DONE) && (phase_q == qdrcd_pkg::PH_LAST)
                       && (credits_q != 2'h0);
  assign cmd_accept  = cmd_ready_o && (wr_req_i || rd_req_i);

  // Launch source: training traffic first, user traffic after
  always_comb begin
    launch_wr   = 1'b0;
    launch_rd   = 1'b0;
    launch_addr = addr_i;
    launch_rise = wdata_rise_i;
    launch_fall = wdata_fall_i;
    if (phase_q == qdrcd_pkg::PH_LAST) begin
      if (cal_q == qdrcd_pkg::CAL_WRITE) begin
        launch_wr   = 1'b1;
        launch_addr = '0;
        launch_rise = PAT_RISE;
        launch_fall = PAT_FALL;
      end else if (cal_q == qdrcd_pkg::CAL_READ) begin
        launch_rd   = 1'b1;
        launch_addr = '0;
      end else if (cmd_accept) begin
        launch_wr = wr_req_i;
        launch_rd = rd_req_i;
      end
    end
  end
  assign launch_fire = launch_wr || launch_rd;

  // Output bank: every memory pin leaves from flops on the same clock
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mem_addr_o  <= '0;
      mem_wr_n_o  <= 1'b1;
      mem_rd_n_o  <= 1'b1;
      mem_d_o     <= '0;
      fall_hold_q <= '0;
      mem_k_o     <= 1'b0;
      mem_k_n_o   <= 1'b1;
    end else begin
      // Pair follows the source phase directly; a second stage would push K onto word edges
      if (phase_q == qdrcd_pkg::PH_LAUNCH) begin
        mem_k_o   <= 1'b1;
        mem_k_n_o <= 1'b0;
      end else if (phase_q == qdrcd_pkg::PH_LAUNCH2) begin
        mem_k_o   <= 1'b0;
        mem_k_n_o <= 1'b1;
      end
      if (phase_q == qdrcd_pkg::PH_LAST) begin
        mem_addr_o  <= launch_addr;
        mem_wr_n_o  <= ~launch_wr;
        mem_rd_n_o  <= ~launch_rd;
        mem_d_o     <= launch_rise;
        fall_hold_q <= launch_fall;
      end else if (phase_q == qdrcd_pkg::PH_KRISE) begin
        mem_d_o <= fall_hold_q; // Second word of the pair
      end
    end
  end

  // Echo clock delay line puts the sampling edge mid window
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      p_sh_q        <= '0;
      strobe_prev_q <= 1'b0;
    end else begin
      p_sh_q        <= ECHO_DLY'({p_sh_q, echo_clock_p_i});
      strobe_prev_q <= strobe;
    end
  end
  assign strobe      = p_sh_q[ECHO_DLY-1];
  assign strobe_rise = strobe && !strobe_prev_q;

  // Inverted strobe: delayed negative echo, or the falling positive echo
  if (USE_DELAY_LINE) begin : g_dly
    logic [ECHO_DLY-1:0] n_sh_q;
    logic                n_prev_q;
    always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        n_sh_q   <= '0;
        n_prev_q <= 1'b0;
      end else begin
        n_sh_q   <= ECHO_DLY'({n_sh_q, echo_clock_n_i});
        n_prev_q <= n_sh_q[ECHO_DLY-1];
      end
    end
    assign strobe_inv_rise = n_sh_q[ECHO_DLY-1] && !n_prev_q;
  end else begin : g_pll
    // Negative echo input is deliberately left unread here
    assign strobe_inv_rise = !strobe && strobe_prev_q;
  end

  // Capture one word per half cycle, recapture the pair on the next strobe rise
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rise_cap_q  <= '0;
      fall_cap_q  <= '0;
      fall_seen_q <= 1'b0;
      pair_rise_q <= '0;
      pair_fall_q <= '0;
      pair_vld_q  <= 1'b0;
    end else begin
      pair_vld_q <= 1'b0;
      if (strobe_inv_rise) begin
        fall_cap_q  <= mem_q_i;
        fall_seen_q <= 1'b1;
      end
      if (strobe_rise) begin
        rise_cap_q  <= mem_q_i;
        pair_rise_q <= rise_cap_q;
        pair_fall_q <= fall_cap_q;
        pair_vld_q  <= fall_seen_q;
        fall_seen_q <= strobe_inv_rise;
      end
    end
  end
  assign pair_match = (pair_rise_q == PAT_RISE) && (pair_fall_q == PAT_FALL);

  // Training: write pattern, read it back, count cycles to the first match
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cal_q     <= qdrcd_pkg::CAL_IDLE;
      cal_cnt_q <= qdrcd_pkg::LAT_RST;
      lat_q     <= qdrcd_pkg::LAT_RST;
    end else begin
      case (cal_q)
        qdrcd_pkg::CAL_IDLE:  cal_q <= qdrcd_pkg::CAL_WRITE;
        qdrcd_pkg::CAL_WRITE: if (launch_wr) cal_q <= qdrcd_pkg::CAL_READ;
        qdrcd_pkg::CAL_READ: begin
          if (launch_rd) begin
            cal_q     <= qdrcd_pkg::CAL_WAIT;
            cal_cnt_q <= 5'h01;
          end
        end
        qdrcd_pkg::CAL_WAIT: begin
          if (pair_vld_q && pair_match) begin
            lat_q <= cal_cnt_q;
            cal_q <= qdrcd_pkg::CAL_DONE;
          end else if (cal_cnt_q == qdrcd_pkg::LAT_MAX) begin
            cal_q <= qdrcd_pkg::CAL_WRITE; // No matching read-back: train again
          end else begin
            cal_cnt_q <= cal_cnt_q + 5'h01;
          end
        end
        qdrcd_pkg::CAL_DONE:  cal_q <= qdrcd_pkg::CAL_DONE;
        default:              cal_q <= qdrcd_pkg::CAL_IDLE;
      endcase
    end
  end
  assign cal_done_o    = (cal_q == qdrcd_pkg::CAL_DONE);
  assign cal_latency_o = lat_q;

  // Read markers age by one per cycle; the calibrated tap releases the pair
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pipe_q <= '0;
    end else begin
      pipe_q <= {pipe_q[qdrcd_pkg::MAX_LAT-2:0], launch_rd && cal_done_o};
    end
  end
  assign deliver = cal_done_o && (lat_q != 5'h00) && pipe_q[lat_q - 5'h01];

  // Credits cover in-flight reads plus buffered words, so no push is refused
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      credits_q <= qdrcd_pkg::CREDITS_RST;
    end else begin
      credits_q <= credits_q - {1'b0, cmd_accept && rd_req_i} + {1'b0, pop};
    end
  end
  assign pop = rdata_valid_o && rdata_ready_i;

  qdrcd_pair_buf #(
    .W (2 * DATA_W)
  ) u_buf (
    .mclk_i      (mclk_i),
    .resetn_i    (resetn_i),
    .in_valid_i  (deliver),
    .in_ready_o  (buf_in_ready),
    .in_data_i   ({pair_rise_q, pair_fall_q}),
    .out_valid_o (rdata_valid_o),
    .out_ready_i (rdata_ready_i),
    .out_data_o  ({rdata_rise_o, rdata_fall_o})
  );

  sequence s_cal_wr;
    cal_q == qdrcd_pkg::CAL_WRITE && launch_wr;
  endsequence
  sequence s_cal_rd;
    cal_q == qdrcd_pkg::CAL_READ && launch_rd;
  endsequence

  a_k_lags_launch: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    $rose(k_q) |-> phase_q == qdrcd_pkg::PH_KRISE)
    else $error("Memory clock source not a quarter behind launch");
  a_cmd_on_launch: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    launch_fire |=> phase_q == qdrcd_pkg::PH_LAUNCH && mem_rd_n_o == !$past(launch_rd))
    else $error("Command not launched on the launch phase");
  a_k_centred: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    $rose(mem_k_o) |-> $stable(mem_d_o) && $stable(mem_addr_o))
    else $error("Memory clock edge not centred on data");
  a_pair_compl: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    mem_k_o != mem_k_n_o)
    else $error("Memory clock pair not complementary");
  a_pair_after_edge: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    pair_vld_q |-> $past(strobe_rise) && $past(fall_seen_q))
    else $error("Pair released without strobe edge and second word");
  a_cal_sequence: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    s_cal_wr |-> ##4 s_cal_rd)
    else $error("Training read did not follow dummy write");
  a_cal_first_match: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    $rose(cal_done_o) |-> $past(pair_vld_q) && $past(pair_match) && lat_q == $past(cal_cnt_q))
    else $error("Latency latched without a matching read-back");
  a_latency_fixed: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    cal_done_o |=> cal_done_o && $stable(lat_q))
    else $error("Latency changed after training");
  a_no_lost_word: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    deliver |-> buf_in_ready)
    else $error("Read word arrived with the buffer full");
  a_credit_bound: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    credits_q <= qdrcd_pkg::CREDITS_RST)
    else $error("Read credits exceed buffer depth");
endmodule
`default_nettype wire

//--- qdrcd_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module qdrcd_mem_model #(
  parameter int unsigned DW      = 18,
  parameter int unsigned AW      = 19,
  parameter int unsigned RD_WAIT = 2
) (
  // Clock
  input  wire logic          mclk_i,
  // From controller, plus the scenario's bad_n_i
  input  wire logic          mem_k_i,
  input  wire logic [AW-1:0] mem_addr_i,
  input  wire logic          mem_wr_n_i,
  input  wire logic          mem_rd_n_i,
  input  wire logic [DW-1:0] mem_d_i,
  input  wire logic          bad_n_i,
  // To controller
  output logic               echo_p_o,
  output logic               echo_n_o,
  output logic [DW-1:0]      q_o
);
  logic [DW-1:0] mem_r [int];
  logic [DW-1:0] mem_f [int];
  int            ra [$];
  int            rdue [$];
  int            wa, ep;
  logic          k_q, wr_pend, cur, junk;
  logic [1:0]    ecnt;

  initial begin
    {k_q, wr_pend, cur, junk, echo_p_o} = '0;
    ecnt = 2'h0;
    ep = 0;
    q_o = '0;
  end

  // Garbage on the negative echo when a scenario asks for it
  assign echo_n_o = bad_n_i ? junk : ~echo_p_o;

  // Commands on K rise, fall word on K fall; echo free-runs from the system clock
  always @(posedge mclk_i) begin
    k_q <= mem_k_i;
    junk <= ~junk;
    ecnt <= ecnt + 2'h1;
    if (mem_k_i && !k_q) begin
      if (!mem_wr_n_i) begin
        wa = int'(mem_addr_i);
        mem_r[wa] = mem_d_i;
      end
      wr_pend <= !mem_wr_n_i;
      if (!mem_rd_n_i) begin
        ra.push_back(int'(mem_addr_i));
        rdue.push_back(ep + RD_WAIT);
      end
    end
    if (!mem_k_i && k_q && wr_pend) begin
      mem_f[wa] = mem_d_i;
    end
    // Data edges coincide with echo edges; idle bus shows a moving pattern
    if (ecnt == 2'h3) begin
      echo_p_o <= 1'b1;
      ep = ep + 1;
      if (ra.size() > 0 && rdue[0] <= ep) begin
        q_o <= mem_r.exists(ra[0]) ? mem_r[ra[0]] : ~q_o;
        cur <= 1'b1;
      end else begin
        q_o <= ~q_o;
      end
    end else if (ecnt == 2'h1) begin
      echo_p_o <= 1'b0;
      if (cur) begin
        q_o <= mem_f.exists(ra[0]) ? mem_f[ra[0]] : ~q_o;
        void'(ra.pop_front());
        void'(rdue.pop_front());
        cur <= 1'b0;
      end else begin
        q_o <= ~q_o;
      end
    end
  end
endmodule
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic        mclk, resetn, wr_req, rd_req, rdata_ready, bad_n, rdy_s;
  logic [18:0] addr;
  logic [17:0] wd_r, wd_f, rd_r, rd_f, d_o, q;
  logic        cmd_ready, rdata_valid, cal_done, k, k_n, wr_n, rd_n, ep, en;
  logic [4:0]  lat;
  logic [18:0] a_o;
  logic [35:0] gotq [$];
  int          gotc [$];
  int          cyc, error_cnt, tests_run, t1, t2;

  initial begin
    mclk = 1'b0;
    resetn = 1'b0;
    {wr_req, rd_req, rdata_ready, bad_n} = '0;
    addr = '0;
    wd_r = '0;
    wd_f = '0;
    cyc = 0;
    error_cnt = 0;
    tests_run = 0;
  end
  always #4 mclk = ~mclk;

  qdrcd_datapath dut (.mclk_i(mclk), .resetn_i(resetn), .cmd_ready_o(cmd_ready),
    .wr_req_i(wr_req), .rd_req_i(rd_req), .addr_i(addr), .wdata_rise_i(wd_r),
    .wdata_fall_i(wd_f), .rdata_valid_o(rdata_valid), .rdata_ready_i(rdata_ready),
    .rdata_rise_o(rd_r), .rdata_fall_o(rd_f), .cal_done_o(cal_done),
    .cal_latency_o(lat), .mem_k_o(k), .mem_k_n_o(k_n), .mem_addr_o(a_o),
    .mem_wr_n_o(wr_n), .mem_rd_n_o(rd_n), .mem_d_o(d_o), .echo_clock_p_i(ep),
    .echo_clock_n_i(en), .mem_q_i(q));

  qdrcd_mem_model #(.DW(18), .AW(19), .RD_WAIT(2)) mem (.mclk_i(mclk), .mem_k_i(k),
    .mem_addr_i(a_o), .mem_wr_n_i(wr_n), .mem_rd_n_i(rd_n), .mem_d_i(d_o),
    .bad_n_i(bad_n), .echo_p_o(ep), .echo_n_o(en), .q_o(q));

  // Sample settled levels mid-cycle; pops land on the following rising edge
  always @(negedge mclk) begin
    rdy_s = cmd_ready;
    if (rdata_valid === 1'b1 && rdata_ready === 1'b1) begin
      gotq.push_back({rd_r, rd_f});
      gotc.push_back(cyc);
    end
    cyc = cyc + 1;
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Hold the request until an edge where the port was ready
  task automatic cmd(input logic w, input logic r, input logic [18:0] a,
                     input logic [17:0] dr, input logic [17:0] df, output int tk);
    @(posedge mclk);
    wr_req <= w;
    rd_req <= r;
    addr <= a;
    wd_r <= dr;
    wd_f <= df;
    for (int i = 0; i < 40; i++) begin
      @(posedge mclk);
      if (rdy_s === 1'b1) break;
    end
    tk = cyc;
    wr_req <= 1'b0;
    rd_req <= 1'b0;
  endtask

  task automatic wait_got(input int n);
    for (int i = 0; i < 200 && gotq.size() < n; i++) @(negedge mclk);
    chk(gotq.size(), n);
  endtask

  task automatic t_reset();
    repeat (16) @(negedge mclk);
    chk({cmd_ready, rdata_valid, cal_done, lat, k, k_n, wr_n, rd_n}, 12'h007);
    chk({a_o, d_o}, 0);
    @(posedge mclk);
    resetn <= 1'b1;
  endtask

  task automatic t_cal();
    int seen;
    seen = 0;
    for (int i = 0; i < 3000 && cal_done !== 1'b1; i++) begin
      @(negedge mclk);
      if (cal_done !== 1'b1 && cmd_ready === 1'b1) seen = 1;
    end
    chk(cal_done, 1);
    chk(seen, 0);
    chk(lat >= 5'h01 && lat <= 5'h1f, 1);
    chk(mem.mem_r[0], qdrcd_pkg::CAL_RISE);
    chk(mem.mem_f[0], qdrcd_pkg::CAL_FALL);
  endtask

  // Words centred on K edges, K pair complementary with a four-cycle period
  task automatic t_write(input logic [18:0] a, input logic [17:0] r, input logic [17:0] f);
    int tk;
    cmd(1'b1, 1'b0, a, r, f, tk);
    @(negedge mclk);
    chk({wr_n, rd_n, a_o, d_o, k, k_n}, {2'b01, a, r, 2'b01});
    @(negedge mclk);
    chk({d_o, k, k_n}, {r, 2'b10});
    @(negedge mclk);
    chk({d_o, k, k_n}, {f, 2'b10});
    @(negedge mclk);
    chk({d_o, k, k_n}, {f, 2'b01});
  endtask

  task automatic t_read_b2b();
    t_write(19'h0_0007, 18'h0_1357, 18'h3_9bdf);
    gotq.delete();
    gotc.delete();
    rdata_ready <= 1'b1;
    cmd(1'b0, 1'b1, 19'h0_0005, '0, '0, t1);
    cmd(1'b0, 1'b1, 19'h0_0007, '0, '0, t2);
    chk(t2 - t1, 4);
    wait_got(2);
    chk(gotq[0], {18'h2_1234, 18'h1_5678});
    chk(gotq[1], {18'h0_1357, 18'h3_9bdf});
    chk(gotc[1] - t2, gotc[0] - t1);
  endtask

  // Receiver stalls: two reads fill the buffer, the command port stays not ready for 60 cycles
  task automatic t_stall();
    int tk, hi;
    hi = 0;
    gotq.delete();
    rdata_ready <= 1'b0;
    cmd(1'b0, 1'b1, 19'h0_0007, '0, '0, tk);
    cmd(1'b0, 1'b1, 19'h0_0005, '0, '0, tk);
    repeat (60) begin
      @(negedge mclk);
      if (cmd_ready === 1'b1) hi = 1;
    end
    chk(hi, 0);
    chk(rdata_valid, 1);
    chk(gotq.size(), 0);
    @(posedge mclk);
    rdata_ready <= 1'b1;
    wait_got(2);
    chk(gotq[0], {18'h0_1357, 18'h3_9bdf});
    chk(gotq[1], {18'h2_1234, 18'h1_5678});
    repeat (2) @(negedge mclk);
    chk(rdata_valid, 0);
  endtask

  // Negative echo carries junk; capture must not depend on it
  task automatic t_echo_n();
    int tk;
    bad_n <= 1'b1;
    gotq.delete();
    cmd(1'b0, 1'b1, 19'h0_0005, '0, '0, tk);
    wait_got(1);
    chk(gotq[0], {18'h2_1234, 18'h1_5678});
    bad_n <= 1'b0;
  endtask

  task automatic final_report();
    $display("Checks run %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Whole sequence is a few hundred cycles; cut a hang well beyond that
  initial begin
    #100000;
    error_cnt++;
    final_report();
  end

  initial begin
    t_reset();
    t_cal();
    t_write(19'h0_0005, 18'h2_1234, 18'h1_5678);
    t_read_b2b();
    t_stall();
    t_echo_n();
    final_report();
  end
endmodule
`default_nettype wire
